// ===== inc/cgl_pkg.sv
/*
 * cgl_pkg: constants for the processor-to-peripheral glue logic.
 * Assumes a 250 MHz system clock; times are in ns, counts derived.
 */
`default_nettype none
package cgl_pkg;
	localparam int CLK_NS = 4;
	// acknowledge read delay after vector-fetch strobe, slow/fast grade
	localparam int ACK_RD_DLY_SLOW_NS = 350;
	localparam int ACK_RD_DLY_FAST_NS = 250;
	// vector valid after acknowledge read strobe, slow/fast grade
	localparam int VEC_VALID_SLOW_NS = 250;
	localparam int VEC_VALID_FAST_NS = 180;
	// least times round up
	localparam int ACK_RD_DLY_SLOW_CYC =
		(ACK_RD_DLY_SLOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACK_RD_DLY_FAST_CYC =
		(ACK_RD_DLY_FAST_NS + CLK_NS - 1) / CLK_NS;
	localparam int VEC_VALID_SLOW_CYC =
		(VEC_VALID_SLOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int VEC_VALID_FAST_CYC =
		(VEC_VALID_FAST_NS + CLK_NS - 1) / CLK_NS;
	// extra wait states on i/o cycles to the fast grade
	localparam int IO_EXTRA_WAIT = 1;
	localparam int SYNC_STAGES = 3;
endpackage
`default_nettype wire

// ===== core/cgl_glue.sv
/*
 * cgl_glue: strobe delay, wait generation and interrupt acknowledge
 * sequencing between an 8-bit processor bus and slower peripherals.
 * Assumes processor pins are asynchronous to i_clk and resynchronised
 * here; all strobes active low. Peripheral clock equals i_clk.
 */
// Behaviour
// - one extra wait on fast-grade reads
// - one extra wait on fast-grade writes
// - peripheral vector valid within 250/180 ns
`timescale 1ns/1ns
`default_nettype none
module cgl_glue
	import cgl_pkg::*;
#(
	parameter bit FAST_GRADE  = 1'b1,
	parameter int CHAIN_EXTRA = 0
) (
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// processor bus, active low, asynchronous
	input  wire logic i_rd_n,
	input  wire logic i_wr_n,
	input  wire logic i_iorq_n,
	input  wire logic i_opcode_cycle_marker_n,
	input  wire logic i_memory_request_n,
	input  wire logic i_periph_sel_n,
	// other system wait request, active low
	input  wire logic i_sys_wait_n,
	// processor side
	output logic      o_wait_n,
	// peripheral side
	output logic      o_read_n,
	output logic      o_write_n,
	output logic      o_vector_fetch_strobe_n
);
	localparam int RD_TAP = (FAST_GRADE ? ACK_RD_DLY_FAST_CYC
		: ACK_RD_DLY_SLOW_CYC) + CHAIN_EXTRA;
	localparam int VEC_CYC = FAST_GRADE ? VEC_VALID_FAST_CYC
		: VEC_VALID_SLOW_CYC;
	localparam int SR_LEN = RD_TAP + VEC_CYC + 1;
	// refuse a chain extension the tap chain cannot hold
	if (CHAIN_EXTRA < 0 || SR_LEN > 1024) begin : g_bad_chain
		$error("cgl_glue: bad CHAIN_EXTRA");
	end

	////////////////////////////////////////////////////////////////////
	// input synchronisers: change counts when stages 2 and 3 agree
	localparam int NIN = 6;
	logic [NIN-1:0] pin_raw;
	logic [NIN-1:0] s1_q;
	logic [NIN-1:0] s2_q;
	logic [NIN-1:0] s3_q;
	logic [NIN-1:0] flt_q;
	logic [NIN-1:0] s1_d;
	logic [NIN-1:0] s2_d;
	logic [NIN-1:0] s3_d;
	logic [NIN-1:0] flt_d;
	assign pin_raw = {i_rd_n, i_wr_n, i_iorq_n, i_opcode_cycle_marker_n,
		i_memory_request_n, i_periph_sel_n};
	always_comb begin
		s1_d = pin_raw;
		s2_d = s1_q;
		s3_d = s2_q;
		flt_d = flt_q;
		for (int k = 0; k < NIN; k++) begin
			if (s2_q[k] == s3_q[k])
				flt_d[k] = s3_q[k];
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_q  <= '1;
			s2_q  <= '1;
			s3_q  <= '1;
			flt_q <= '1;
		end else begin
			s1_q  <= s1_d;
			s2_q  <= s2_d;
			s3_q  <= s3_d;
			flt_q <= flt_d;
		end
	end
	logic rd_n;
	logic wr_n;
	logic iorq_n;
	logic m1_n;
	logic memory_request_n;
	logic sel_n;
	assign {rd_n, wr_n, iorq_n, m1_n, memory_request_n, sel_n} = flt_q;

	// i/o cycle decode, shared by read and write
	function automatic logic io_cycle(
		input logic strb_n,
		input logic cyc_n,
		input logic dev_n,
		input logic mark_n
	);
		return !strb_n && !cyc_n && !dev_n && mark_n;
	endfunction

	////////////////////////////////////////////////////////////////////
	// i/o cycle: delayed strobe fall and, on fast grade only, one extra wait state
	logic       rd_dly_q;
	logic       rd_dly_d;
	logic       wr_dly_q;
	logic       wr_dly_d;
	logic [1:0] xw_q;
	logic [1:0] xw_d;
	logic       io_rd;
	logic       io_wr;
	assign io_rd = io_cycle(rd_n, iorq_n, sel_n, m1_n);
	assign io_wr = io_cycle(wr_n, iorq_n, sel_n, m1_n);
	always_comb begin
		rd_dly_d = io_rd;
		wr_dly_d = io_wr;
		xw_d = xw_q;
		if (!(io_rd || io_wr))
			xw_d = 2'(0);
		else if (FAST_GRADE && xw_q <= 2'(IO_EXTRA_WAIT))
			xw_d = xw_q + 2'(1);
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_dly_q <= 1'b0;
			wr_dly_q <= 1'b0;
			xw_q     <= 2'h0;
		end else begin
			rd_dly_q <= rd_dly_d;
			wr_dly_q <= wr_dly_d;
			xw_q     <= xw_d;
		end
	end
	logic io_wait;
	// wait while extra wait states still count
	assign io_wait = FAST_GRADE && (io_rd || io_wr)
		&& xw_q <= 2'(IO_EXTRA_WAIT);

	////////////////////////////////////////////////////////////////////
	// acknowledge shift register
	logic [SR_LEN-1:0] sr_q, sr_d;
	logic ack_seen;
	assign ack_seen = !m1_n && memory_request_n;
	always_comb begin
		if (m1_n)
			sr_d = '0;
		else
			sr_d = {sr_q[SR_LEN-2:0], ack_seen};
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			sr_q <= '0;
		else
			sr_q <= sr_d;
	end

	////////////////////////////////////////////////////////////////////
	// outputs from flip-flops; read and write strobes are also forced low by i_rst
	logic fetch_q;
	logic aread_q;
	logic await_q;
	logic rd_o_q;
	logic wr_o_q;
	logic wait_o_q;
	logic fetch_d;
	logic aread_d;
	logic await_d;
	logic rd_o_d;
	logic wr_o_d;
	logic wait_o_d;
	always_comb begin
		fetch_d = sr_q[0];
		aread_d = sr_q[RD_TAP];
		// wait until read tap plus vector time
		await_d = sr_q[0] && !sr_q[SR_LEN-1];
		rd_o_d = !(rd_dly_q && io_rd) && !aread_d;
		wr_o_d = !(wr_dly_q && io_wr);
		wait_o_d = i_sys_wait_n && !io_wait && !await_d;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fetch_q  <= 1'b0;
			aread_q  <= 1'b0;
			await_q  <= 1'b0;
			rd_o_q   <= 1'b0;
			wr_o_q   <= 1'b0;
			wait_o_q <= 1'b1;
		end else begin
			fetch_q  <= fetch_d;
			aread_q  <= aread_d;
			await_q  <= await_d;
			rd_o_q   <= rd_o_d;
			wr_o_q   <= wr_o_d;
			wait_o_q <= wait_o_d;
		end
	end
	assign o_read_n  = rd_o_q && !i_rst;
	assign o_write_n = wr_o_q && !i_rst;
	assign o_vector_fetch_strobe_n = !fetch_q;
	assign o_wait_n = wait_o_q;
endmodule // cgl_glue
`default_nettype wire

// ===== tb/cgl_periph.sv
/* peripheral model: vector valid after acknowledge read.
   assumes fast grade and peripheral clock equal to i_clk */
`timescale 1ns/1ns
`default_nettype none
module cgl_periph
	import cgl_pkg::*;
(
	input  wire logic i_clk, i_read_n, i_fetch_n,
	output logic      o_vec_ok
);
	int cnt_q;
	always_ff @(posedge i_clk)
		cnt_q <= (i_read_n | i_fetch_n) ? 0 : cnt_q + 1;
	assign o_vec_ok = cnt_q >= VEC_VALID_FAST_CYC;
endmodule // cgl_periph
`default_nettype wire

// ===== tb/cgl_glue_assertions.sv
/* glue checker: timing relations at the ports.
   bound to every cgl_glue instance */
`timescale 1ns/1ns
`default_nettype none
module cgl_chk
	import cgl_pkg::*;
#(parameter bit FAST_GRADE = 1'b1) (
	input wire logic i_clk, i_rst, i_rd_n, i_wr_n, i_iorq_n,
	input wire logic i_opcode_cycle_marker_n, i_memory_request_n,
	input wire logic i_periph_sel_n, i_sys_wait_n, o_wait_n,
	input wire logic o_read_n, o_write_n, o_vector_fetch_strobe_n
);
	localparam int GAP = FAST_GRADE ? ACK_RD_DLY_FAST_CYC
		: ACK_RD_DLY_SLOW_CYC;
	localparam int VEC = FAST_GRADE ? VEC_VALID_FAST_CYC
		: VEC_VALID_SLOW_CYC;
	int fc_q;
	int rc_q;
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			fc_q <= 0;
		else
			fc_q <= o_vector_fetch_strobe_n ? 0 : fc_q + 1;
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			rc_q <= 0;
		else
			rc_q <= o_read_n ? 0 : rc_q + 1;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	rst_force_a: assert property (disable iff (1'b0)
		i_rst |-> !o_read_n && !o_write_n) else $error("reset strobes");
	ack_detect_a: assert property ($fell(o_vector_fetch_strobe_n)
		|-> $past(!i_opcode_cycle_marker_n && i_memory_request_n, 3))
		else $error("fetch without acknowledge");
	op_skip_a: assert property ((!i_opcode_cycle_marker_n
		&& !i_memory_request_n)[*8] |-> o_vector_fetch_strobe_n)
		else $error("fetch in opcode cycle");
	ack_gap_a: assert property ($fell(o_read_n)
		&& !o_vector_fetch_strobe_n |-> fc_q >= GAP)
		else $error("fetch to read too short");
	vec_wait_a: assert property ($rose(o_wait_n)
		&& !o_vector_fetch_strobe_n |-> !o_read_n && rc_q >= VEC)
		else $error("wait released early");
	wr_delay_a: assert property ($fell(o_write_n)
		|-> $past(!i_wr_n && !i_iorq_n, 2)) else $error("write early");
	rd_delay_a: assert property ($fell(o_read_n)
		&& o_vector_fetch_strobe_n |-> $past(!i_rd_n, 3))
		else $error("read early");
	sys_wait_a: assert property (!i_sys_wait_n[*3] |-> !o_wait_n)
		else $error("wait not passed");
endmodule // cgl_chk
bind cgl_glue cgl_chk #(.FAST_GRADE(FAST_GRADE)) cgl_chk_inst (.*);
`default_nettype wire

// ===== tb/tb_cgl_glue.sv
/* tb_cgl_glue: reset, io, acknowledge, opcode and wait scenarios.
   assumes default fast grade parameters */
`timescale 1ns/1ns
`default_nettype none
module tb_cgl_glue;
	import cgl_pkg::*;
	logic i_clk = 0, i_rst = 0, i_rd_n = 1, i_wr_n = 1, i_iorq_n = 1;
	logic i_opcode_cycle_marker_n = 1, i_memory_request_n = 1;
	logic i_periph_sel_n = 1, i_sys_wait_n = 1, vec_ok;
	logic o_wait_n, o_read_n, o_write_n, o_vector_fetch_strobe_n;
	int bad_count = 0, n_compared = 0;
	cgl_glue cgl_glue_inst (.*);
	cgl_periph cgl_periph_inst (.i_clk(i_clk), .i_read_n(o_read_n),
		.i_fetch_n(o_vector_fetch_strobe_n), .o_vec_ok(vec_ok));
	initial forever #2 i_clk = ~i_clk;
	task automatic chk(string s, logic e, logic g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %b got %b", s, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic til(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v) begin
			@(negedge i_clk);
			n++;
			if (n > 500) begin
				bad_count++;
				wrap_up();
			end
		end
	endtask
	task automatic t_io(input bit wr);
		int w = 0;
		bit held = 0;
		i_iorq_n = 0;
		i_periph_sel_n = 0;
		i_wr_n = !wr;
		i_rd_n = wr;
		repeat (20) begin
			@(negedge i_clk);
			if (w > 0 && o_wait_n && !held) begin
				chk("io hold", 0, wr ? o_write_n : o_read_n);
				held = 1;
			end
			w += !o_wait_n;
		end
		chk("io strobe", 0, wr ? o_write_n : o_read_n);
		chk("io wait", 1, w == IO_EXTRA_WAIT + 1);
		{i_iorq_n, i_periph_sel_n, i_wr_n, i_rd_n} = 4'hF;
		repeat (10) @(negedge i_clk);
		$display("io end");
	endtask
	task automatic t_ack;
		int b;
		i_opcode_cycle_marker_n = 0;
		til(o_vector_fetch_strobe_n, 0, b);
		chk("fetch delay", 1, b == 6);
		chk("ack wait", 0, o_wait_n);
		til(o_read_n, 0, b);
		chk("ack gap", 1, b >= ACK_RD_DLY_FAST_CYC);
		til(o_wait_n, 1, b);
		chk("vector", 1, vec_ok);
		i_opcode_cycle_marker_n = 1;
		repeat (10) @(negedge i_clk);
		chk("ack end", 1, o_read_n & o_vector_fetch_strobe_n);
		$display("ack end");
	endtask
	task automatic t_opf;
		int f = 0;
		i_opcode_cycle_marker_n = 0;
		i_memory_request_n = 0;
		i_sys_wait_n = 0;
		repeat (12) begin
			@(negedge i_clk);
			f += !o_vector_fetch_strobe_n;
		end
		chk("opfetch", 1, f == 0);
		chk("sys wait", 0, o_wait_n);
		{i_opcode_cycle_marker_n, i_memory_request_n, i_sys_wait_n} = 3'h7;
		repeat (10) @(negedge i_clk);
		$display("opcode end");
	endtask
	task automatic t_rst;
		i_rst = 1;
		repeat (2) @(negedge i_clk);
		chk("rst strobes", 0, o_read_n | o_write_n);
		chk("rst idle", 1, o_wait_n & o_vector_fetch_strobe_n);
		i_rst = 0;
		repeat (8) @(negedge i_clk);
		chk("rst release", 1, o_read_n & o_write_n);
		$display("reset end");
	endtask
	initial begin
		#1 i_rst = 1;
		repeat (5) @(negedge i_clk);
		chk("rst strobes", 0, o_read_n | o_write_n);
		i_rst = 0;
		repeat (8) @(negedge i_clk);
		t_io(0);
		t_io(1);
		t_ack();
		t_opf();
		t_rst();
		t_io(1);
		wrap_up();
	end
endmodule // tb_cgl_glue
`default_nettype wire
